// *** include/bdsb_pkg.sv ***
// Behaviour
// - Processor clock is board clock halved.
// - Power-on or key reset cleaned, fanned out.
// - Memory 0000-0FFF selects monitor ROM socket.
// - Memory 2000-2FFF selects expansion socket.
// - Memory 1800-1FFF selects 2K system RAM.
// - I/O bits 7:6 pick parallel, timer, PARALLEL_IO_CHIP.
// - I/O bits 5:0 ignored, sixty-four aliases.
// - Host drives segments on eight lines.
// - Host enables digits on six lines.
// - Key returns low on press; 32 keys.
// - User key shown on key port bit 6.
// - Host sends tape and audio on one line.
// - Tape playback level on key port bit 7.
// - Break arm high clears counter, NMI high, unless monitor key presets.
// - Armed counter drops NMI on fifth fetch.
// - Mod-five carry sets top; NMI inverts top.
// - Monitor key presets nine, forcing NMI low.
// - Timer outranks PARALLEL_IO_CHIP in interrupt chain.
package bdsb_pkg;
   // ==========================================================
   // Clock and timing.
   localparam int CLK_MHZ         = 40;
   localparam int RST_HOLD_NS     = 10000;
   localparam int RST_HOLD_CYC    = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_CNT_W       = 9;

   // ==========================================================
   // Address decode values.
   localparam logic [3:0] ROM_A15_12 = 4'h0;
   localparam logic [3:0] EXP_A15_12 = 4'h2;
   localparam logic [3:0] RAM_A15_12 = 4'h1;
   localparam logic [1:0] IO_PAR     = 2'h0;
   localparam logic [1:0] IO_TIMER   = 2'h1;
   localparam logic [1:0] IO_PIO     = 2'h2;
   localparam int         KEYS_USED  = 32;
   localparam int         DIGITS     = 6;
   localparam logic [2:0] STEP_LAST  = 3'h4;

   // ==========================================================
   // Host register offsets and reset values.
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_BUS    = 8'h04;
   localparam logic [7:0]  OFS_STAT   = 8'h08;
   localparam logic [7:0]  OFS_ISTAT  = 8'h0C;
   localparam logic [7:0]  OFS_IMASK  = 8'h10;
   localparam logic [31:0] CTRL_RST   = 32'h0000_8000;
   localparam logic [31:0] BUS_RST    = 32'h0000_0000;
   localparam int          IRQ_W      = 3;
   localparam int          EV_NMI     = 0;
   localparam int          EV_KEY     = 1;
   localparam int          EV_INT     = 2;
endpackage : bdsb_pkg

// *** include/bdsb_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Processor-side bus between the board glue and the host.
interface bdsb_link_if;
   logic        cpuClock;
   logic        cpuReset_n;
   logic [15:0] address;
   logic        memoryRequest_n;
   logic        ioRequest_n;
   logic        opcodeFetchCycle_n;
   logic [7:0]  segmentDriveLines;
   logic [5:0]  digitSelectLines;
   logic        tapeAudioOutput;
   logic        breakArmLine;
   logic [7:0]  keyPort;
   logic        nmi_n;
   logic        intReq_n;
   logic [5:0]  select_n;

   modport board (
      output cpuClock, cpuReset_n, keyPort, nmi_n, intReq_n, select_n,
      input  address, memoryRequest_n, ioRequest_n, opcodeFetchCycle_n,
      input  segmentDriveLines, digitSelectLines, tapeAudioOutput,
      input  breakArmLine
   );
   modport host (
      input  cpuClock, cpuReset_n, keyPort, nmi_n, intReq_n, select_n,
      output address, memoryRequest_n, ioRequest_n, opcodeFetchCycle_n,
      output segmentDriveLines, digitSelectLines, tapeAudioOutput,
      output breakArmLine
   );
endinterface : bdsb_link_if
`default_nettype wire

// *** hdl/bdsb_step_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
// Decade-style step counter: mod-five low section plus a top stage.
module bdsb_step_counter (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       counterClearInput,
   input  wire logic       presetNineInput,
   input  wire logic       countEn,
   output logic [2:0]      lowCount,
   output logic            counterTopStage
);
   import bdsb_pkg::*;

   logic [2:0] low_d;
   logic       top_d;
   wire        carry = countEn && (lowCount == STEP_LAST);

   // Preset outranks clear; a set top stage freezes counting.
   always_comb begin
      low_d = lowCount;
      top_d = counterTopStage;
      if (presetNineInput) begin
         low_d = 3'h4;
         top_d = 1'b1;
      end else if (counterClearInput) begin
         low_d = 3'h0;
         top_d = 1'b0;
      end else if (countEn && !counterTopStage) begin
         low_d = carry ? 3'h0 : lowCount + 3'h1;
         top_d = carry;
      end
   end

   // State update.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lowCount        <= 3'h0;
         counterTopStage <= 1'b0;
      end else begin
         lowCount        <= low_d;
         counterTopStage <= top_d;
      end
   end
endmodule : bdsb_step_counter
`default_nettype wire

// *** hdl/bdsb_board.sv ***
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Board glue: clock, reset, decode, key port, step break, daisy chain.
module bdsb_board #(
   parameter int HOLD_CYC = bdsb_pkg::RST_HOLD_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   bdsb_link_if.board       link,
   input  wire logic        resetKey,
   input  wire logic        monitorKey,
   input  wire logic        userKeyInput,
   input  wire logic        tapeInputLine,
   input  wire logic [35:0] keysPressed,
   input  wire logic        timerIntReq,
   input  wire logic        pioIntReq,
   output logic             timerReset_n,
   output logic             parallelReset,
   output logic             pioChainEnable,
   output logic [7:0]       segmentOut,
   output logic [5:0]       digitOut,
   output logic             speakerOut
);
   import bdsb_pkg::*;

   if (HOLD_CYC < 1 || HOLD_CYC >= (1 << RST_CNT_W)) begin : g_chk
      $error("HOLD_CYC out of range");
   end

   // ==========================================================
   // Pin synchronisers.
   // Keys, tape and request pins are not timed to this clock, so each
   // is resampled twice to keep a metastable level out of the logic.
   localparam int NSYNC = 42;
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   wire  [NSYNC-1:0] pinsIn = {resetKey, monitorKey, userKeyInput,
                               tapeInputLine, keysPressed,
                               timerIntReq, pioIntReq};

   // Two flops before any logic reads a pin.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= pinsIn;
         sync_q <= meta_q;
      end
   end

   wire        resetKeyS   = sync_q[41];
   wire        monitorKeyS = sync_q[40];
   wire        userKeyS    = sync_q[39];
   wire        tapeS       = sync_q[38];
   wire [35:0] keysS       = sync_q[37:2];
   wire        timerReqS   = sync_q[1];
   wire        pioReqS     = sync_q[0];

   // ==========================================================
   // Processor clock: a toggle flop halves the board clock.
   logic cpuClock_q;

   always_ff @(posedge clock) begin
      if (!rst_n) cpuClock_q <= 1'b0;
      else        cpuClock_q <= ~cpuClock_q;
   end
   assign link.cpuClock = cpuClock_q;

   // ==========================================================
   // Reset shaping: held while asserted and stretched after release.
   // A bounce of the reset key reloads the stretch, so the processor
   // leaves reset only once the key has been quiet for the hold time.
   logic [RST_CNT_W-1:0] hold_q;
   logic                 cpuReset_q;
   logic                 parReset_q;
   wire                  holdDone = (hold_q == '0);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hold_q     <= RST_CNT_W'(HOLD_CYC);
         cpuReset_q <= 1'b0;
         parReset_q <= 1'b1;
      end else begin
         if (resetKeyS)      hold_q <= RST_CNT_W'(HOLD_CYC);
         else if (!holdDone) hold_q <= hold_q - 1'b1;
         cpuReset_q <= holdDone && !resetKeyS;
         parReset_q <= !(holdDone && !resetKeyS);
      end
   end
   assign link.cpuReset_n = cpuReset_q;
   assign timerReset_n    = cpuReset_q;
   assign parallelReset   = parReset_q;

   // ==========================================================
   // Memory and I/O chip selects, registered, active low.
   wire [3:0] hiNib   = link.address[15:12];
   wire [1:0] ioField = link.address[7:6];
   wire       memOn   = !link.memoryRequest_n;
   wire       ioOn    = !link.ioRequest_n;
   wire       romHit  = memOn && (hiNib == ROM_A15_12);
   wire       expHit  = memOn && (hiNib == EXP_A15_12);
   wire       ramHit  = memOn && (hiNib == RAM_A15_12)
                        && link.address[11];
   wire       parHit  = ioOn && (ioField == IO_PAR);
   wire       timHit  = ioOn && (ioField == IO_TIMER);
   wire       pioHit  = ioOn && (ioField == IO_PIO);
   logic [5:0] select_q;

   // Order: ROM, expansion, RAM, parallel, timer, PARALLEL_IO_CHIP (bit 5 down).
   always_ff @(posedge clock) begin
      if (!rst_n) select_q <= 6'h3F;
      else        select_q <= ~{romHit, expHit, ramHit,
                                parHit, timHit, pioHit};
   end
   assign link.select_n = select_q;

   // ==========================================================
   // Key port: returns of the enabled digit, user key, tape level.
   logic [5:0] keyRet;
   logic [7:0] keyPort_q;

   // A pressed key among the first 32 pulls its return low while its digit is enabled.
   always_comb begin
      keyRet = 6'h3F;
      for (int d = 0; d < DIGITS; d++) begin
         for (int r = 0; r < 6; r++) begin
            if (link.digitSelectLines[d] && keysS[d*6+r]
                && (d*6+r) < KEYS_USED)
               keyRet[r] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) keyPort_q <= 8'h3F;
      else        keyPort_q <= {tapeS, userKeyS, keyRet};
   end
   assign link.keyPort = keyPort_q;

   // ==========================================================
   // Display and speaker drivers follow the host lines.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         segmentOut <= 8'h00;
         digitOut   <= 6'h00;
         speakerOut <= 1'b0;
      end else begin
         segmentOut <= link.segmentDriveLines;
         digitOut   <= link.digitSelectLines;
         speakerOut <= link.tapeAudioOutput;
      end
   end

   // ==========================================================
   // Step counter: counts each opcode fetch start while armed.
   // Only the first low cycle of a fetch strobe counts, so a long strobe
   // still advances the count by exactly one.
   logic fetchPrev_q;
   logic nmi_q;
   logic counterTopStage;
   wire  fetchStart = fetchPrev_q && !link.opcodeFetchCycle_n;

   always_ff @(posedge clock) begin
      if (!rst_n) fetchPrev_q <= 1'b1;
      else        fetchPrev_q <= link.opcodeFetchCycle_n;
   end

   bdsb_step_counter u_stepCounter (
      .clock             (clock),
      .rst_n             (rst_n),
      .counterClearInput (link.breakArmLine),
      .presetNineInput   (monitorKeyS),
      .countEn           (fetchStart),
      .lowCount          (),
      .counterTopStage   (counterTopStage)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) nmi_q <= 1'b1;
      else        nmi_q <= ~counterTopStage;
   end
   assign link.nmi_n = nmi_q;

   // ==========================================================
   // Interrupt chain: timer first, PARALLEL_IO_CHIP enabled only when timer idle.
   // The request line is the OR of both chips; the enable withholds the
   // lower-priority turn while the timer still asks.
   logic intReq_q;
   logic pioEn_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         intReq_q <= 1'b1;
         pioEn_q  <= 1'b1;
      end else begin
         intReq_q <= !(timerReqS || pioReqS);
         pioEn_q  <= !timerReqS;
      end
   end
   assign link.intReq_n  = intReq_q;
   assign pioChainEnable = pioEn_q;
endmodule : bdsb_board
`default_nettype wire

// *** hdl/bdsb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host end: APB registers drive the processor-side lines.
module bdsb_host (
   input  wire logic        clock,
   input  wire logic        rst_n,
   bdsb_link_if.host        link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   import bdsb_pkg::*;

   // ==========================================================
   // APB decode: one wait state, answer on the second access cycle.
   wire       access  = psel && penable;
   wire       done    = access && pready;
   wire [7:0] ofs     = paddr[7:0];
   wire       hiZero  = (paddr[31:8] == 24'h0);
   wire       hitCtrl = hiZero && (ofs == OFS_CTRL);
   wire       hitBus  = hiZero && (ofs == OFS_BUS);
   wire       hitStat = hiZero && (ofs == OFS_STAT);
   wire       hitIst  = hiZero && (ofs == OFS_ISTAT);
   wire       hitImsk = hiZero && (ofs == OFS_IMASK);
   wire       mapped  = hitCtrl | hitBus | hitStat | hitIst | hitImsk;
   wire       wrDone  = done && pwrite;

   logic [31:0]      ctrl_q;
   logic [31:0]      bus_q;
   logic [IRQ_W-1:0] istat_q;
   logic [IRQ_W-1:0] imask_q;
   logic             nmiPrev_q;
   logic             keyPrev_q;
   logic             intPrev_q;

   wire        keyDown = (link.keyPort[5:0] != 6'h3F);
   wire [31:0] status  = {14'h0, link.cpuReset_n, link.cpuClock,
                          link.select_n, link.intReq_n, link.nmi_n,
                          link.keyPort};
   wire [IRQ_W-1:0] events;
   assign events[EV_NMI] = nmiPrev_q && !link.nmi_n;
   assign events[EV_KEY] = !keyPrev_q && keyDown;
   assign events[EV_INT] = intPrev_q && !link.intReq_n;

   wire [31:0] rdMux = hitCtrl ? ctrl_q :
                       hitBus  ? bus_q :
                       hitStat ? status :
                       hitIst  ? {29'h0, istat_q} :
                       hitImsk ? {29'h0, imask_q} : 32'h0;

   // Bus answer.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= access && !pready;
         pslverr <= access && !pready && !mapped;
         prdata  <= (access && !pready && !pwrite) ? rdMux : 32'h0;
      end
   end

   // Control and bus-line registers.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_q <= CTRL_RST;
         bus_q  <= BUS_RST;
      end else begin
         if (wrDone && hitCtrl) ctrl_q <= {16'h0, pwdata[15:0]};
         if (wrDone && hitBus)  bus_q  <= {13'h0, pwdata[18:0]};
      end
   end

   // Sticky events: a new event beats a write-one clear.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         istat_q   <= '0;
         imask_q   <= '0;
         nmiPrev_q <= 1'b1;
         keyPrev_q <= 1'b0;
         intPrev_q <= 1'b1;
         irq       <= 1'b0;
      end else begin
         istat_q   <= (istat_q & ~((wrDone && hitIst) ?
                       pwdata[IRQ_W-1:0] : '0)) | events;
         if (wrDone && hitImsk) imask_q <= pwdata[IRQ_W-1:0];
         nmiPrev_q <= link.nmi_n;
         keyPrev_q <= keyDown;
         intPrev_q <= link.intReq_n;
         irq       <= |(istat_q & imask_q);
      end
   end

   // Processor-side lines straight from the registers.
   assign link.segmentDriveLines  = ctrl_q[7:0];
   assign link.digitSelectLines   = ctrl_q[13:8];
   assign link.tapeAudioOutput    = ctrl_q[14];
   assign link.breakArmLine       = ctrl_q[15];
   assign link.address            = bus_q[15:0];
   assign link.memoryRequest_n    = ~bus_q[16];
   assign link.ioRequest_n        = ~bus_q[17];
   assign link.opcodeFetchCycle_n = ~bus_q[18];
endmodule : bdsb_host
`default_nettype wire

// *** tb/bdsb_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Link monitor: processor clock, chip selects and step break.
module bdsb_link_monitor (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        cpuClock,
   input wire logic [15:0] address,
   input wire logic        memoryRequest_n,
   input wire logic        ioRequest_n,
   input wire logic        opcodeFetchCycle_n,
   input wire logic        breakArmLine,
   input wire logic        nmi_n,
   input wire logic [5:0]  select_n
);
   logic       romHit, expHit, ramHit, fetchStart, fetchHigh_q;
   logic [2:0] ioHit, fetchCount_q;

   default clocking monCb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Selects expected from the request and the address lines.
   assign romHit = !memoryRequest_n && address[15:12] == 4'h0;
   assign expHit = !memoryRequest_n && address[15:12] == 4'h2;
   assign ramHit = !memoryRequest_n && address[15:11] == 5'h03;
   assign ioHit = {3{!ioRequest_n}} & {address[7:6] == 2'h0,
                  address[7:6] == 2'h1, address[7:6] == 2'h2};
   assign fetchStart = !opcodeFetchCycle_n && fetchHigh_q;

   // Counts fetch starts while armed; a high arm line clears it.
   always_ff @(posedge clock) begin
      fetchHigh_q <= !rst_n || opcodeFetchCycle_n;
      if (!rst_n || breakArmLine) fetchCount_q <= 3'h0;
      else if (fetchStart && fetchCount_q != 3'h5)
         fetchCount_q <= fetchCount_q + 3'h1;
   end

   // ==========================================================
   // Checks on the link.
   clock_half_a: assert property (
      $past(rst_n) |-> cpuClock != $past(cpuClock))
      else $error("processor clock did not toggle");
   rom_select_a: assert property (
      $past(rst_n) |-> select_n[5] == !$past(romHit))
      else $error("monitor ROM select wrong");
   exp_select_a: assert property (
      $past(rst_n) |-> select_n[4] == !$past(expHit))
      else $error("expansion select wrong");
   ram_select_a: assert property (
      $past(rst_n) |-> select_n[3] == !$past(ramHit))
      else $error("system RAM select wrong");
   io_select_a: assert property (
      $past(rst_n) |-> select_n[2:0] == ~$past(ioHit))
      else $error("peripheral select wrong");
   arm_clear_a: assert property (
      breakArmLine [*4] |-> nmi_n)
      else $error("interrupt low while armed high");
   fifth_fetch_a: assert property (
      fetchStart && !breakArmLine && fetchCount_q == 3'h4
      |-> ##[2:3] !nmi_n)
      else $error("no interrupt after fifth fetch");
   nmi_hold_a: assert property (
      !nmi_n && !breakArmLine |=> !nmi_n)
      else $error("interrupt released before clear");

   // Main scenarios reached.
   cover property (!select_n[5]);
   cover property (!select_n[1]);
   cover property ($fell(nmi_n));
endmodule : bdsb_link_monitor
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench: both ends joined, the host end driven over APB.
module testbench;
   import bdsb_pkg::*;
   localparam int          HOLD  = 4;
   localparam int          LIMIT = 8000;
   localparam logic [15:0] MEM_A [10] = '{16'h0000, 16'h0FFF, 16'h1000,
      16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'h2FFF, 16'h3000, 16'hF800};
   localparam logic [15:0] IO_A [8] = '{16'h0000, 16'h0003, 16'h003F,
      16'h0040, 16'h007C, 16'h0080, 16'h00BF, 16'h00C0};
   localparam int          KEY_IX [8] = '{0, 7, 14, 21, 28, 31, 32, 35};
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic        resetKey = 1'b0;
   logic        monitorKey = 1'b0;
   logic        userKeyInput = 1'b0;
   logic        tapeInputLine = 1'b0;
   logic [35:0] keysPressed = '0;
   logic        timerIntReq = 1'b0;
   logic        pioIntReq = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, speakerOut;
   logic        timerReset_n, parallelReset, pioChainEnable;
   logic [7:0]  segmentOut;
   logic [5:0]  digitOut;
   int          errTotal = 0;
   int          nCompared = 0;
   int          cycles = 0;
   // Copies of the host lines on the display and speaker drivers.
   wire [31:0]  lineCopy = {17'h0, speakerOut, digitOut, segmentOut};

   // The two ends face each other across one link.
   bdsb_link_if bdsb_link_if_inst ();
   bdsb_board #(.HOLD_CYC(HOLD)) bdsb_board_inst (
      .clock(clock), .rst_n(rst_n), .link(bdsb_link_if_inst.board),
      .resetKey(resetKey), .monitorKey(monitorKey),
      .userKeyInput(userKeyInput), .tapeInputLine(tapeInputLine),
      .keysPressed(keysPressed), .timerIntReq(timerIntReq),
      .pioIntReq(pioIntReq), .timerReset_n(timerReset_n),
      .parallelReset(parallelReset), .pioChainEnable(pioChainEnable),
      .segmentOut(segmentOut), .digitOut(digitOut), .speakerOut(speakerOut));
   bdsb_host bdsb_host_inst (
      .clock(clock), .rst_n(rst_n), .link(bdsb_link_if_inst.host),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq));
   bdsb_link_monitor bdsb_link_monitor_inst (
      .clock(clock), .rst_n(rst_n),
      .cpuClock(bdsb_link_if_inst.cpuClock),
      .address(bdsb_link_if_inst.address),
      .memoryRequest_n(bdsb_link_if_inst.memoryRequest_n),
      .ioRequest_n(bdsb_link_if_inst.ioRequest_n),
      .opcodeFetchCycle_n(bdsb_link_if_inst.opcodeFetchCycle_n),
      .breakArmLine(bdsb_link_if_inst.breakArmLine),
      .nmi_n(bdsb_link_if_inst.nmi_n),
      .select_n(bdsb_link_if_inst.select_n));

   // Clock, and a cycle ceiling that cuts a hang short.
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errTotal++;
         finalReport();
      end
   end

   // ==========================================================
   // Comparison, bus and verdict tasks.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h expected %h",
                  $time, got, exp);
         errTotal++;
      end
   endtask : check

   // One APB transfer, held until pready is seen high.
   task automatic apb_xfer(input logic wr, input logic [31:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : apb_xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb_xfer(1'b1, {24'h0, a}, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      apb_xfer(1'b0, {24'h0, a}, 32'h0, rd, err);
      check(rd & m, exp & m);
   endtask : rd_chk

   // Active-low selects expected for a request and address.
   function automatic logic [5:0] sel_exp(input logic m, input logic i,
                                          input logic [15:0] a);
      return ~{m && a[15:12] == 4'h0, m && a[15:12] == 4'h2,
               m && a[15:11] == 5'h03, i && a[7:6] == 2'h0,
               i && a[7:6] == 2'h1, i && a[7:6] == 2'h2};
   endfunction : sel_exp

   task automatic finalReport();
      if (errTotal == 0 && nCompared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finalReport

   // ==========================================================
   // Main sequence.
   initial begin
      logic [31:0] rdv;
      logic        errv;
      logic [5:0]  keyExp;
      int          d;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      // Reset values, reserved bits, refused addresses, line copies.
      rd_chk(OFS_CTRL, 32'hFFFFFFFF, CTRL_RST);
      rd_chk(OFS_BUS, 32'hFFFFFFFF, BUS_RST);
      wr(OFS_BUS, 32'hFFFFFFFF);
      rd_chk(OFS_BUS, 32'hFFFFFFFF, 32'h0007FFFF);
      wr(OFS_CTRL, 32'hFFFFFFFF);
      rd_chk(OFS_CTRL, 32'hFFFFFFFF, 32'h0000FFFF);
      check(lineCopy, 32'h7FFF);
      apb_xfer(1'b1, 32'h100, 32'h0, rdv, errv);
      check({31'h0, errv}, 32'h1);
      apb_xfer(1'b0, 32'h14, 32'h0, rdv, errv);
      check({rdv[30:0], errv}, 32'h1);
      wr(OFS_CTRL, 32'h0000D5A3);
      check(lineCopy, 32'h55A3);
      rd_chk(OFS_STAT, 32'h20000, 32'h20000);
      check({30'h0, timerReset_n, parallelReset}, 32'h2);
      resetKey <= 1'b1;
      repeat (4) @(posedge clock);
      rd_chk(OFS_STAT, 32'h20000, 32'h0);
      check({30'h0, timerReset_n, parallelReset}, 32'h1);
      resetKey <= 1'b0;
      repeat (HOLD + 6) @(posedge clock);
      rd_chk(OFS_STAT, 32'h20000, 32'h20000);
      // Memory and peripheral decode, aliases included.
      wr(OFS_BUS, 32'h0);
      rd_chk(OFS_STAT, 32'hFC00, 32'hFC00);
      for (int k = 0; k < 10; k++) begin
         wr(OFS_BUS, {13'h0, 3'b001, MEM_A[k]});
         rd_chk(OFS_STAT, 32'hFC00,
                {16'h0, sel_exp(1, 0, MEM_A[k]), 10'h0});
      end
      for (int k = 0; k < 8; k++) begin
         wr(OFS_BUS, {13'h0, 3'b010, IO_A[k]});
         rd_chk(OFS_STAT, 32'hFC00,
                {16'h0, sel_exp(0, 1, IO_A[k]), 10'h0});
      end
      wr(OFS_BUS, 32'h0);
      // Key returns per digit, user key and tape level.
      for (int k = 0; k < 8; k++) begin
         d = KEY_IX[k] / 6;
         keysPressed   <= 36'h1 << KEY_IX[k];
         userKeyInput  <= k[0];
         tapeInputLine <= k[1];
         wr(OFS_CTRL, 32'h8000 | (32'h100 << d));
         keyExp = (KEY_IX[k] < 32) ? ~(6'h1 << (KEY_IX[k] % 6)) : 6'h3F;
         rd_chk(OFS_STAT, 32'hFF,
                {24'h0, k[1], k[0], keyExp});
         wr(OFS_CTRL, 32'h8000 | (32'h100 << ((d + 1) % 6)));
         rd_chk(OFS_STAT, 32'h3F, 32'h3F);
      end
      // Interrupt status, mask and clear.
      keysPressed <= '0;
      wr(OFS_ISTAT, 32'h7);
      rd_chk(OFS_ISTAT, 32'h7, 32'h0);
      keysPressed <= 36'h1;
      // Two sync stages, the key port and the event flop come first.
      repeat (5) @(posedge clock);
      rd_chk(OFS_ISTAT, 32'h7, 32'h2);
      check({31'h0, irq}, 32'h0);
      wr(OFS_IMASK, 32'h2);
      check({31'h0, irq}, 32'h1);
      wr(OFS_IMASK, 32'h0);
      check({31'h0, irq}, 32'h0);
      wr(OFS_IMASK, 32'h7);
      keysPressed <= '0;
      wr(OFS_ISTAT, 32'h2);
      check({31'h0, irq}, 32'h0);
      // Timer outranks the parallel chip in the chain.
      timerIntReq <= 1'b1;
      repeat (4) @(posedge clock);
      check({31'h0, pioChainEnable}, 32'h0);
      rd_chk(OFS_STAT, 32'h200, 32'h0);
      timerIntReq <= 1'b0;
      pioIntReq   <= 1'b1;
      repeat (4) @(posedge clock);
      check({31'h0, pioChainEnable}, 32'h1);
      rd_chk(OFS_ISTAT, 32'h4, 32'h4);
      pioIntReq <= 1'b0;
      // Let the release pass the synchroniser and the request flop.
      repeat (4) @(posedge clock);
      rd_chk(OFS_STAT, 32'h200, 32'h200);
      wr(OFS_ISTAT, 32'h7);
      // Step break, twice, to show the arm line restarts the count.
      for (int rep = 0; rep < 2; rep++) begin
         wr(OFS_CTRL, 32'h0);
         for (int f = 1; f <= 6; f++) begin
            wr(OFS_BUS, 32'h00040000);
            wr(OFS_BUS, 32'h0);
            rd_chk(OFS_STAT, 32'h100,
                   (f < 5) ? 32'h100 : 32'h0);
         end
         rd_chk(OFS_ISTAT, 32'h1, 32'h1);
         check({31'h0, irq}, 32'h1);
         wr(OFS_ISTAT, 32'h7);
         wr(OFS_CTRL, 32'h8000);
         rd_chk(OFS_STAT, 32'h100, 32'h100);
      end
      // Monitor key forces the interrupt with no fetch at all.
      wr(OFS_CTRL, 32'h0);
      monitorKey <= 1'b1;
      repeat (8) @(posedge clock);
      monitorKey <= 1'b0;
      rd_chk(OFS_STAT, 32'h100, 32'h0);
      wr(OFS_CTRL, 32'h8000);
      rd_chk(OFS_STAT, 32'h100, 32'h100);
      finalReport();
   end
endmodule : testbench
`default_nettype wire
